// ===== inc/csr_pkg.sv
// Shared constants and types for the chip-select and refresh block
package csr_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Select channels
    localparam int unsigned CSR_NSEL = 10;
    localparam int unsigned CSR_NGEN = 8;
    localparam int unsigned CSR_IDX_LOWER = 8;
    localparam int unsigned CSR_IDX_UPPER = 9;
    localparam int unsigned CSR_IDX_W = 4;
    localparam int unsigned CSR_FIELD_W = 10;
    localparam int unsigned CSR_WAIT_W = 4;
    localparam int unsigned CSR_ADDR_W = 20;

    // Address bit positions of the compared field
    localparam int unsigned CSR_MEM_FIELD_LSB = 10;
    localparam int unsigned CSR_IO_FIELD_LSB = 6;

    // Peripheral register block spans 256 bytes
    localparam int unsigned CSR_PRB_BASE_W = 12;
    localparam int unsigned CSR_PRB_LSB = 8;

    ////////////////////////////////////////////////////////////////////////
    // Refresh sub-unit
    localparam int unsigned CSR_TMR_W = 9;
    localparam int unsigned CSR_ROW_W = 12;
    localparam int unsigned CSR_RBASE_W = 7;
    localparam logic [CSR_TMR_W-1:0] CSR_TMR_RST = 9'h1ff;
    localparam logic [CSR_ROW_W-1:0] CSR_ROW_RST = 12'h000;

    ////////////////////////////////////////////////////////////////////////
    // Reset values of a select
    localparam logic [CSR_FIELD_W-1:0] CSR_UPPER_START_RST = 10'h3ff;
    localparam logic [CSR_FIELD_W-1:0] CSR_UPPER_STOP_RST = 10'h3ff;
    localparam logic [CSR_WAIT_W-1:0] CSR_UPPER_WAIT_RST = 4'hf;
    localparam logic [CSR_FIELD_W-1:0] CSR_OFF_START_RST = 10'h3ff;
    localparam logic [CSR_FIELD_W-1:0] CSR_OFF_STOP_RST = 10'h000;

    typedef struct packed {
        logic [CSR_FIELD_W-1:0] start;
        logic [CSR_FIELD_W-1:0] stop;
        logic enable;
        logic io_space;
        logic [CSR_WAIT_W-1:0] waits;
        logic use_ready;
    } csr_sel_cfg_t;

    typedef enum logic [1:0] {
        CSR_ST_IDLE,
        CSR_ST_WAIT,
        CSR_ST_HOLD
    } csr_state_t;

endpackage

// ===== hdl/csr_unit.sv
// Chip-select decoder with wait-state control and memory refresh sub-unit
//
// Summary of operation
// R1 - Ten selects, each programmable for memory or I/O space.
// R2 - After reset only the upper boot select is on, top 1 Kbyte memory.
// R3 - Ten-bit start/stop compare on upper address bits: 1 K memory, 64 B I/O.
// R4 - A select never asserts when start exceeds stop or it is disabled.
// R5 - Programmed waits come first; ready sampled afterwards only if used.
// R6 - Selects ignoring ready end the cycle after their programmed waits.
// R7 - Overlapping windows: every matching select asserts together.
// R8 - If any match uses ready, insert smallest wait count before sampling.
// R9 - If no match uses ready, insert largest wait count then terminate.
// R10 - No select asserts inside the peripheral register block range.
// R11 - Generic selects reach pins only when the port mux picks them.
// R12 - Refresh read is requested whenever the 9-bit interval counter expires.
// R13 - Refresh cycles show the 12-bit row counter on address bits 12:1.
// R14 - Row counter advances only after a refresh cycle really ran.
// R15 - Address bits 19:13 come from a programmable base during refresh.
// R16 - Select decoding stays active during refresh cycles.
// R17 - Refresh drives upper byte strobe and address bit 0 high.
// R18 - Pending refresh drops hold acknowledge; requester must release hold.
// R19 - Asserted selects last the whole cycle and drop when it ends.
module csr_unit (
    input wire logic mclk_i,
    input wire logic rst_n_i,
    // Select configuration load
    input wire logic cfg_we_i,
    input wire logic [csr_pkg::CSR_IDX_W-1:0] cfg_idx_i,
    input wire csr_pkg::csr_sel_cfg_t cfg_data_i,
    // Peripheral register block placement
    input wire logic [csr_pkg::CSR_PRB_BASE_W-1:0] prb_base_i,
    input wire logic prb_io_i,
    // Port multiplexer for generic select pins
    input wire logic [csr_pkg::CSR_NGEN-1:0] port_mux_sel_i,
    input wire logic [csr_pkg::CSR_NGEN-1:0] port_data_i,
    // Refresh configuration
    input wire logic rfsh_en_i,
    input wire logic [csr_pkg::CSR_TMR_W-1:0] rfsh_interval_i,
    input wire logic [csr_pkg::CSR_RBASE_W-1:0] rfsh_base_i,
    // Core bus cycle request
    input wire logic cyc_req_i,
    input wire logic [csr_pkg::CSR_ADDR_W-1:0] cyc_addr_i,
    input wire logic cyc_io_i,
    input wire logic cyc_byte_hi_n_i,
    // External bus handshakes
    input wire logic ready_i,
    input wire logic hold_i,
    output logic hold_ack_o,
    // Bus outputs
    output logic [csr_pkg::CSR_NGEN-1:0] generic_select_outputs_o,
    output logic lower_sel_n_o,
    output logic upper_boot_select_n_o,
    output logic [csr_pkg::CSR_ADDR_W-1:0] bus_addr_o,
    output logic upper_byte_strobe_n_o,
    output logic bus_busy_o,
    output logic cyc_done_o,
    output logic rfsh_cyc_o,
    output logic rfsh_pend_o,
    output logic [csr_pkg::CSR_ROW_W-1:0] rfsh_row_o
);
    import csr_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // State

    typedef struct packed {
        csr_state_t st;
        csr_sel_cfg_t [CSR_NSEL-1:0] cfg;
        logic [CSR_NSEL-1:0] sel_n;
        logic [CSR_NGEN-1:0] pins;
        logic [CSR_ADDR_W-1:0] addr;
        logic byte_hi_n;
        logic [CSR_WAIT_W-1:0] wcnt;
        logic use_rdy;
        logic busy;
        logic rfsh_cyc;
        logic done;
        logic hold_ack;
        logic [CSR_TMR_W-1:0] tmr;
        logic pend;
        logic [CSR_ROW_W-1:0] row;
    } csr_unit_t;

    csr_unit_t s_r;
    csr_unit_t s_nxt;

    ////////////////////////////////////////////////////////////////////////
    // Decode helpers

    // Address falls inside the peripheral register block
    function automatic logic in_prb(
        input logic [CSR_ADDR_W-1:0] a,
        input logic io
    );
        in_prb = (io == prb_io_i) &&
                 (a[CSR_ADDR_W-1:CSR_PRB_LSB] == prb_base_i); // R10
    endfunction

    // One select's window check; I/O compares the 64-byte field
    function automatic logic sel_hit(
        input csr_sel_cfg_t c,
        input logic [CSR_ADDR_W-1:0] a,
        input logic io
    );
        logic [CSR_FIELD_W-1:0] f;
        f = io ? a[CSR_IO_FIELD_LSB+CSR_FIELD_W-1:CSR_IO_FIELD_LSB]
               : a[CSR_MEM_FIELD_LSB+CSR_FIELD_W-1:CSR_MEM_FIELD_LSB]; // R3
        sel_hit = c.enable && (c.io_space == io) &&
                  (c.start <= c.stop) && // R4
                  (f >= c.start) && (f <= c.stop) && // R1
                  !in_prb(a, io); // R10
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Cycle start: decode all selects and pick the wait count

    logic [CSR_ADDR_W-1:0] start_addr;
    logic start_io;
    logic [CSR_NSEL-1:0] hits;
    logic any_rdy;
    logic [CSR_WAIT_W-1:0] w_min;
    logic [CSR_WAIT_W-1:0] w_max;

    always_comb begin
        // Refresh address: base on 8 Kbyte boundary, row on bits 12:1
        if (s_r.pend) begin
            start_addr = {rfsh_base_i, s_r.row, 1'b1}; // R13 R15 R17
            start_io = 1'b0;
        end else begin
            start_addr = cyc_addr_i;
            start_io = cyc_io_i;
        end
        hits = '0;
        any_rdy = 1'b0;
        w_min = '1;
        w_max = '0;
        for (int i = 0; i < CSR_NSEL; i++) begin
            // Decode runs identically for refresh and core cycles
            hits[i] = sel_hit(s_r.cfg[i], start_addr, start_io); // R7 R16
            if (hits[i]) begin
                any_rdy = any_rdy | s_r.cfg[i].use_ready;
                if (s_r.cfg[i].waits < w_min) begin
                    w_min = s_r.cfg[i].waits;
                end
                if (s_r.cfg[i].waits > w_max) begin
                    w_max = s_r.cfg[i].waits;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Next state

    logic tmr_expired;
    logic rfsh_taken;

    always_comb begin
        s_nxt = s_r;
        s_nxt.done = 1'b0;
        tmr_expired = 1'b0;
        rfsh_taken = 1'b0;

        // Interval counter reloads on expiry; a disabled unit stays loaded
        if (!rfsh_en_i) begin
            s_nxt.tmr = rfsh_interval_i;
        end else if (s_r.tmr == '0) begin
            s_nxt.tmr = rfsh_interval_i;
            tmr_expired = 1'b1; // R12
        end else begin
            s_nxt.tmr = s_r.tmr - 1'b1;
        end

        if (cfg_we_i && (cfg_idx_i < CSR_IDX_W'(CSR_NSEL))) begin
            s_nxt.cfg[cfg_idx_i] = cfg_data_i;
        end

        unique case (s_r.st)
            CSR_ST_IDLE: begin
                if (s_r.pend || cyc_req_i) begin
                    rfsh_taken = s_r.pend;
                    s_nxt.st = CSR_ST_WAIT;
                    s_nxt.busy = 1'b1;
                    s_nxt.addr = start_addr;
                    s_nxt.sel_n = ~hits; // R7 R16
                    s_nxt.rfsh_cyc = s_r.pend;
                    s_nxt.byte_hi_n = s_r.pend | cyc_byte_hi_n_i; // R17
                    if (hits == '0) begin
                        // No select: external ready alone ends the cycle
                        s_nxt.wcnt = '0;
                        s_nxt.use_rdy = 1'b1;
                    end else if (any_rdy) begin
                        s_nxt.wcnt = w_min; // R8
                        s_nxt.use_rdy = 1'b1;
                    end else begin
                        s_nxt.wcnt = w_max; // R9
                        s_nxt.use_rdy = 1'b0;
                    end
                end else if (hold_i) begin
                    s_nxt.st = CSR_ST_HOLD;
                    s_nxt.hold_ack = 1'b1;
                end
            end
            CSR_ST_WAIT: begin
                if (s_r.wcnt != '0) begin
                    s_nxt.wcnt = s_r.wcnt - 1'b1; // R5
                end else if (!s_r.use_rdy || ready_i) begin // R5 R6
                    s_nxt.st = CSR_ST_IDLE;
                    s_nxt.sel_n = '1; // R19
                    s_nxt.busy = 1'b0;
                    s_nxt.done = 1'b1;
                    s_nxt.rfsh_cyc = 1'b0;
                    if (s_r.rfsh_cyc) begin
                        s_nxt.row = s_r.row + 1'b1; // R14
                    end
                end
            end
            CSR_ST_HOLD: begin
                // Refresh outranks the external master; it must let go
                if (s_r.pend) begin
                    s_nxt.hold_ack = 1'b0; // R18
                end
                if (!hold_i) begin
                    s_nxt.st = CSR_ST_IDLE; // R18
                    s_nxt.hold_ack = 1'b0;
                end
            end
        endcase

        // Expiry in the cycle a request is taken still leaves one pending
        s_nxt.pend = (tmr_expired | (s_r.pend & ~rfsh_taken)) & rfsh_en_i;

        for (int i = 0; i < CSR_NGEN; i++) begin
            s_nxt.pins[i] = port_mux_sel_i[i] ? s_nxt.sel_n[i]
                                               : port_data_i[i]; // R11
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Registers

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s_r.st <= CSR_ST_IDLE;
            for (int i = 0; i < CSR_NSEL; i++) begin
                s_r.cfg[i].start <= CSR_OFF_START_RST;
                s_r.cfg[i].stop <= CSR_OFF_STOP_RST;
                s_r.cfg[i].enable <= 1'b0;
                s_r.cfg[i].io_space <= 1'b0;
                s_r.cfg[i].waits <= CSR_UPPER_WAIT_RST;
                s_r.cfg[i].use_ready <= 1'b1;
            end
            // Boot ROM reachable straight out of reset
            s_r.cfg[CSR_IDX_UPPER].start <= CSR_UPPER_START_RST; // R2
            s_r.cfg[CSR_IDX_UPPER].stop <= CSR_UPPER_STOP_RST; // R2
            s_r.cfg[CSR_IDX_UPPER].enable <= 1'b1; // R2
            s_r.sel_n <= '1;
            s_r.pins <= '1;
            s_r.addr <= '0;
            s_r.byte_hi_n <= 1'b1;
            s_r.wcnt <= '0;
            s_r.use_rdy <= 1'b0;
            s_r.busy <= 1'b0;
            s_r.rfsh_cyc <= 1'b0;
            s_r.done <= 1'b0;
            s_r.hold_ack <= 1'b0;
            s_r.tmr <= CSR_TMR_RST;
            s_r.pend <= 1'b0;
            s_r.row <= CSR_ROW_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs

    assign generic_select_outputs_o = s_r.pins;
    assign lower_sel_n_o = s_r.sel_n[CSR_IDX_LOWER];
    assign upper_boot_select_n_o = s_r.sel_n[CSR_IDX_UPPER];
    assign bus_addr_o = s_r.addr;
    assign upper_byte_strobe_n_o = s_r.byte_hi_n;
    assign bus_busy_o = s_r.busy;
    assign cyc_done_o = s_r.done;
    assign rfsh_cyc_o = s_r.rfsh_cyc;
    assign rfsh_pend_o = s_r.pend;
    assign rfsh_row_o = s_r.row;
    assign hold_ack_o = s_r.hold_ack;

endmodule

// ===== sim/csr_unit_asserts.sv
// Port assertions for the select and refresh unit
module csr_unit_asserts (
    input wire logic mclk_i,
    input wire logic rst_n_i,
    input wire logic [7:0] port_mux_sel_i,
    input wire logic [7:0] port_data_i,
    input wire logic [6:0] rfsh_base_i,
    input wire logic hold_ack_o,
    input wire logic [7:0] generic_select_outputs_o,
    input wire logic lower_sel_n_o,
    input wire logic upper_boot_select_n_o,
    input wire logic [19:0] bus_addr_o,
    input wire logic upper_byte_strobe_n_o,
    input wire logic bus_busy_o,
    input wire logic cyc_done_o,
    input wire logic rfsh_cyc_o,
    input wire logic rfsh_pend_o,
    input wire logic [11:0] rfsh_row_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!rst_n_i);
    ////////////////////////////////////////////////////////////////////////
    a_done_pulse: assert property (cyc_done_o |=> !cyc_done_o)
        else $error("done longer than a cycle");
    a_done_end: assert property ($fell(bus_busy_o) |-> cyc_done_o)
        else $error("cycle ended without done");
    a_idle_quiet: assert property (!bus_busy_o |->
        lower_sel_n_o && upper_boot_select_n_o)
        else $error("select active while idle");
    a_rfsh_strobe: assert property (rfsh_cyc_o |->
        upper_byte_strobe_n_o && bus_addr_o[0] && bus_busy_o)
        else $error("refresh strobe or bit 0 low");
    a_rfsh_addr: assert property (rfsh_cyc_o |->
        bus_addr_o[19:1] == {rfsh_base_i, rfsh_row_o})
        else $error("refresh address wrong");
    a_row_step: assert property ($changed(rfsh_row_o) |->
        $past(rfsh_cyc_o) && rfsh_row_o == $past(rfsh_row_o) + 12'h1)
        else $error("row moved outside refresh");
    a_rfsh_pend: assert property ($rose(rfsh_cyc_o) |-> $past(rfsh_pend_o))
        else $error("refresh without request");
    a_hold_abort: assert property (rfsh_pend_o && hold_ack_o |=> !hold_ack_o)
        else $error("hold ack kept with refresh pending");
    a_hold_quiet: assert property (hold_ack_o |-> !bus_busy_o)
        else $error("bus cycle during hold");
    a_port_pin: assert property ($past(rst_n_i) |->
        ((generic_select_outputs_o ^ $past(port_data_i))
        & ~$past(port_mux_sel_i)) == 8'h00)
        else $error("port pin data wrong");
endmodule

// ===== sim/csr_mem_model.sv
// Memory side: ready after a set delay, line wanders when not addressed
module csr_mem_model (
    input wire logic mclk_i,
    input wire logic rst_n_i,
    input wire logic bus_busy_i,
    input wire logic [3:0] lat_i,
    output logic ready_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [4:0] cnt_r;
    logic tog_r;
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt_r <= 5'h00;
            tog_r <= 1'b0;
        end else begin
            cnt_r <= bus_busy_i ? cnt_r + 5'h01 : 5'h00;
            tog_r <= ~tog_r;
        end
    end
    assign ready_o = bus_busy_i ? (cnt_r >= {1'b0, lat_i}) : tog_r;
endmodule

// ===== sim/csr_unit_test.sv
// Self-checking bench for the select and refresh unit
module csr_unit_test;
    timeunit 1ns;
    timeprecision 1ps;
    import csr_pkg::*;
    logic mclk_i = 0, rst_n_i = 0, cfg_we_i = 0, prb_io_i = 1, rfsh_en_i = 0;
    logic cyc_req_i = 0, cyc_io_i = 0, cyc_byte_hi_n_i = 1, hold_i = 0;
    logic [3:0] cfg_idx_i = 4'h0, lat = 4'h0;
    csr_sel_cfg_t cfg_data_i = '0;
    csr_sel_cfg_t cfg [10];
    logic [11:0] prb_base_i = 12'h000;
    logic [7:0] port_mux_sel_i = 8'hff, port_data_i = 8'h00;
    logic [8:0] rfsh_interval_i = 9'h01f;
    logic [6:0] rfsh_base_i = 7'h40;
    logic [19:0] cyc_addr_i = 20'h00000, bus_addr_o, a;
    logic ready_i, hold_ack_o, lower_sel_n_o, upper_boot_select_n_o, io;
    logic upper_byte_strobe_n_o, bus_busy_o, cyc_done_o, rfsh_cyc_o;
    logic rfsh_pend_o;
    logic [7:0] generic_select_outputs_o;
    logic [11:0] rfsh_row_o;
    int failures = 0, samples_checked = 0, n;
    longint t, tp;
    csr_unit uut (.*);
    csr_mem_model mem (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
        .bus_busy_i(bus_busy_o), .lat_i(lat), .ready_o(ready_i));
    initial forever #5 mclk_i = ~mclk_i;
    ////////////////////////////////////////////////////////////////////////
    task automatic wrap_up();
        $display("Checks %0d, mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic chk(logic [31:0] seen, logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            failures++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic tick(int k = 1);
        repeat (k) @(posedge mclk_i);
        #1;
    endtask
    task automatic wr(int i, csr_sel_cfg_t c);
        cfg_idx_i = 4'(i);
        cfg_data_i = c;
        cfg_we_i = 1;
        tick();
        cfg_we_i = 0;
        cfg[i] = c;
    endtask
    task automatic cfg_reset();
        for (int i = 0; i < 9; i++) cfg[i] = '{10'h3ff, 10'h000, 0, 0, 4'hf, 1};
        cfg[9] = '{10'h3ff, 10'h3ff, 1, 0, 4'hf, 1};
    endtask
    function automatic logic [9:0] hits(logic [19:0] ad, logic s);
        logic [9:0] f, h;
        f = s ? ad[15:6] : ad[19:10];
        for (int i = 0; i < 10; i++)
            h[i] = cfg[i].enable && cfg[i].start <= cfg[i].stop &&
                f >= cfg[i].start && f <= cfg[i].stop && cfg[i].io_space == s;
        if (prb_io_i == s && ad[19:8] == prb_base_i) h = 10'h000;
        return h;
    endfunction
    task automatic sels(logic [9:0] exp_n);
        chk({upper_boot_select_n_o, lower_sel_n_o, generic_select_outputs_o},
            exp_n);
    endtask
    // Waits and ready rule worked out here, then one core cycle is timed
    task automatic bus(logic [19:0] ad, logic s);
        logic [9:0] h;
        int w, m, u;
        h = hits(ad, s);
        u = 0;
        w = 15;
        m = 0;
        for (int i = 0; i < 10; i++) if (h[i]) begin
            u |= cfg[i].use_ready;
            w = cfg[i].waits < w ? cfg[i].waits : w;
            m = cfg[i].waits > m ? cfg[i].waits : m;
        end
        if (h == 0) begin
            u = 1;
            w = 0;
        end else if (!u) w = m;
        cyc_addr_i = ad;
        cyc_io_i = s;
        cyc_byte_hi_n_i = 1'($urandom);
        cyc_req_i = 1;
        n = 1;
        tick();
        cyc_req_i = 0;
        sels(10'(~h));
        chk(upper_byte_strobe_n_o, cyc_byte_hi_n_i);
        while (!cyc_done_o && n < 60) begin
            tick();
            n++;
        end
        chk(n, (u && lat > w) ? lat + 2 : w + 2);
        tick();
    endtask
    task automatic rnd_cfg();
        for (int i = 0; i < 10; i++)
            wr(i, '{10'h100 + 10'($urandom_range(7)),
                10'h100 + 10'($urandom_range(7)), $urandom_range(7) != 0,
                1'($urandom), 4'($urandom), 1'($urandom)});
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        void'($urandom(70306));
        cfg_reset();
        tick(20);
        rst_n_i = 1;
        sels(10'h3ff);
        chk(rfsh_row_o, 0);
        bus(20'hffff0, 0);
        bus(20'hffbf0, 0);
        rnd_cfg();
        repeat (80) begin
            io = 1'($urandom);
            a = {10'h100 + 10'($urandom_range(7)), 10'($urandom)};
            if (io) a = {4'h0, a[19:10], a[5:0]};
            prb_io_i = 1'($urandom);
            prb_base_i = $urandom_range(3) == 0 ? a[19:8] : 12'h000;
            lat = 4'($urandom_range(5));
            bus(a, io);
            if ($urandom_range(9) == 0) rnd_cfg();
        end
        wr(0, '{10'h200, 10'h21f, 1, 0, 4'h1, 0});
        rfsh_en_i = 1;
        for (int k = 0; k < 3; k++) begin
            for (n = 0; !rfsh_cyc_o && n < 100; n++) tick();
            chk(rfsh_cyc_o, 1);
            t = $time;
            if (k > 0) chk(32'((t - tp) / 10), 32);
            tp = t;
            chk(bus_addr_o, {7'h40, 12'(k), 1'b1});
            chk(upper_byte_strobe_n_o, 1);
            sels(10'h3fe);
            for (n = 0; !cyc_done_o && n < 20; n++) tick();
            tick();
            chk(rfsh_row_o, k + 1);
        end
        rfsh_en_i = 0;
        hold_i = 1;
        tick(2);
        chk(hold_ack_o, 1);
        rfsh_en_i = 1;
        for (n = 0; !rfsh_pend_o && n < 100; n++) tick();
        chk(rfsh_pend_o, 1);
        tick(5);
        chk({hold_ack_o, rfsh_cyc_o}, 0);
        hold_i = 0;
        for (n = 0; !rfsh_cyc_o && n < 5; n++) tick();
        chk(rfsh_cyc_o, 1);
        rfsh_en_i = 0;
        tick(20);
        port_mux_sel_i = 8'h0f;
        port_data_i = 8'($urandom);
        tick(2);
        chk(generic_select_outputs_o, {port_data_i[7:4], 4'hf});
        // Pins back to selects so the boot check below sees select levels
        port_mux_sel_i = 8'hff;
        tick(2);
        chk(generic_select_outputs_o, 8'hff);
        rst_n_i = 0;
        tick(3);
        rst_n_i = 1;
        cfg_reset();
        chk(rfsh_row_o, 0);
        bus(20'hffc00, 0);
        wrap_up();
    end
    // About 1000 cycles are needed; the limit of 40000 cycles is forty times that
    initial begin
        #400us;
        failures++;
        wrap_up();
    end
endmodule
bind csr_unit csr_unit_asserts u_chk (.*);
